// *** logic/cable_eq_pkg.sv ***
// constants and types shared by the cable equalizer signal detect control
package cable_eq_pkg;
  // register offsets
  localparam logic [7:0] SLEEP_CONTROL_ADDR = 8'h03;
  localparam logic [7:0] PIN_TWO_FUNCTION_ADDR = 8'h12;
  localparam logic [7:0] PIN_TWO_OUTPUT_ENABLE_ADDR = 8'h13;
  localparam logic [7:0] OUTPUT_ON_LOSS_ADDR = 8'h14;
  localparam logic [7:0] CARRIER_DETECT_CONFIG_ADDR = 8'h15;
  localparam logic [7:0] SQUELCH_SETTINGS_ADDR = 8'h16;
  localparam logic [7:0] EQUALIZER_BYPASS_CONTROL_ADDR = 8'h17;
  localparam logic [7:0] LAUNCH_SWING_SETTING_ADDR = 8'h18;
  localparam logic [7:0] CD_WINDOW_SIZE_ADDR = 8'h20;
  localparam logic [7:0] CD_DROP_COUNT_ADDR = 8'h21;
  localparam logic [7:0] CD_RISE_COUNT_ADDR = 8'h22;
  localparam logic [7:0] CARRIER_CHANGE_COUNTERS_ADDR = 8'h84;
  localparam logic [7:0] LIVE_STATUS_A_ADDR = 8'h86;
  localparam logic [7:0] LIVE_STATUS_B_ADDR = 8'h87;
  localparam logic [7:0] CABLE_LENGTH_READING_ADDR = 8'h88;
  // field positions
  localparam int AUTO_SLEEP_BIT = 0;
  localparam int MANUAL_SLEEP_BIT = 1;
  localparam int SLEEP_DRIVER_DISABLE_BIT = 2;
  localparam int MUTE_ON_LOSS_BIT = 0;
  localparam int DISABLE_ON_LOSS_BIT = 1;
  localparam int SQUELCH_ENABLE_BIT = 0;
  localparam int EQ_AUTO_BYPASS_BIT = 0;
  localparam int EQ_FORCED_BYPASS_BIT = 1;
  localparam int PIN_OUTPUT_ENABLE_BIT = 0;
  localparam int THRESHOLD_LSB = 0;
  localparam int HYSTERESIS_LSB = 6;
  localparam int LOCK_BIT = 0;
  localparam int SQUELCH_STATUS_BIT = 1;
  localparam int PRIMARY_CD_BIT = 3;
  localparam int SECONDARY_CD_BIT = 4;
  // reset values
  localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h01;
  localparam logic [7:0] PIN_TWO_FUNCTION_RESET = 8'h83;
  localparam logic [7:0] PIN_TWO_OUTPUT_ENABLE_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_ON_LOSS_RESET = 8'h00;
  localparam logic [7:0] CARRIER_DETECT_CONFIG_RESET = 8'h00;
  localparam logic [7:0] SQUELCH_SETTINGS_RESET = 8'h60;
  localparam logic [7:0] EQUALIZER_BYPASS_CONTROL_RESET = 8'h01;
  localparam logic [7:0] LAUNCH_SWING_RESET = 8'h50;
  localparam logic [7:0] CD_WINDOW_SIZE_RESET = 8'h3b;
  localparam logic [7:0] CD_DROP_COUNT_RESET = 8'h01;
  localparam logic [7:0] CD_RISE_COUNT_RESET = 8'h44;
  // general pin function codes
  localparam logic [7:0] PIN_FUNCTION_SLEEP = 8'h83;
  localparam logic [7:0] PIN_FUNCTION_EQ_BYPASS = 8'h84;
  // timing
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int CD_TICK_NS = 1600;
  localparam int CD_TICK_CYCLES = (CD_TICK_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] CD_TICK_LAST = 8'(CD_TICK_CYCLES - 1);
  localparam logic [3:0] CHANGE_COUNT_MAX = 4'hf;
  typedef enum logic [1:0] {
    CD_ABSENT = 2'b01,
    CD_PRESENT = 2'b10
  } cd_state_type;
endpackage : cable_eq_pkg

// *** logic/cd_filter_if.sv ***
// carrier detect filter settings and result between control and filter
`timescale 1ns/1ns
interface cd_filter_if;
  logic [7:0] sample_window;
  logic [7:0] rise_count;
  logic [7:0] drop_count;
  logic tick;
  logic raw_carrier;
  logic primary_carrier_detect;
  modport ctrl (
    output sample_window,
    output rise_count,
    output drop_count,
    output tick,
    output raw_carrier,
    input primary_carrier_detect
  );
  modport filter (
    input sample_window,
    input rise_count,
    input drop_count,
    input tick,
    input raw_carrier,
    output primary_carrier_detect
  );
endinterface : cd_filter_if

// *** logic/cd_filter.sv ***
// primary carrier detect filter with sample window and assert/de-assert counts
`timescale 1ns/1ns
module cd_filter (
  input wire logic clock_in,
  input wire logic rst_n_in,
  cd_filter_if.filter cd
);
  cable_eq_pkg::cd_state_type state;
  cable_eq_pkg::cd_state_type next_state;
  logic [7:0] tick_count;
  logic [7:0] next_tick_count;
  logic [7:0] window_count;
  logic [7:0] next_window_count;
  logic [8:0] window_len;
  logic [7:0] target;
  logic present;

  always_comb begin
    next_state = state;
    next_tick_count = tick_count;
    next_window_count = window_count;
    present = (state == cable_eq_pkg::CD_PRESENT);
    window_len = {1'b0, cd.sample_window} + 9'h001;
    target = present ? cd.drop_count : cd.rise_count;
    if (target == 8'h00) begin
      target = 8'h01;
    end
    if (cd.tick) begin
      if (cd.raw_carrier == present) begin
        next_tick_count = 8'h00;
        next_window_count = 8'h00;
      end else if ({1'b0, tick_count} + 9'h001 >= window_len) begin
        // one whole window of opposite samples
        next_tick_count = 8'h00;
        if (window_count + 8'h01 >= target) begin
          next_window_count = 8'h00;
          case (state)
            cable_eq_pkg::CD_ABSENT: next_state = cable_eq_pkg::CD_PRESENT;
            cable_eq_pkg::CD_PRESENT: next_state = cable_eq_pkg::CD_ABSENT;
            default: next_state = cable_eq_pkg::CD_ABSENT;
          endcase
        end else begin
          next_window_count = window_count + 8'h01;
        end
      end else begin
        next_tick_count = tick_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= cable_eq_pkg::CD_ABSENT;
      tick_count <= 8'h00;
      window_count <= 8'h00;
    end else begin
      state <= next_state;
      tick_count <= next_tick_count;
      window_count <= next_window_count;
    end
  end

  assign cd.primary_carrier_detect = (state == cable_eq_pkg::CD_PRESENT);
endmodule : cd_filter

// *** logic/cable_eq_signal_detect_ctrl.sv ***
// sleep, bypass, carrier detect, squelch and loss control for a cable equalizer
`timescale 1ns/1ns
module cable_eq_signal_detect_ctrl (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  output logic [7:0] reg_rdata_out,
  input wire logic raw_carrier_in,
  input wire logic low_rate_in,
  input wire logic [7:0] cable_length_in,
  input wire logic cdr_lock_in,
  input wire logic [2:0] detected_rate_in,
  input wire logic general_pin_two_in,
  output logic general_pin_two_out,
  output logic general_pin_two_oe_out,
  output logic sleep_out,
  output logic driver_mute_out,
  output logic driver_disable_out,
  output logic pattern_gen_disable_out,
  output logic eq_bypass_out,
  output logic cdr_bypass_out,
  output logic [7:0] launch_swing_comp_out,
  output logic signal_loss_out,
  output logic lock_out
);
  logic rst_sync_first;
  logic rst_n;
  logic [7:0] sleep_control;
  logic [7:0] next_sleep_control;
  logic [7:0] pin_two_function;
  logic [7:0] next_pin_two_function;
  logic [7:0] pin_two_output_enable;
  logic [7:0] next_pin_two_output_enable;
  logic [7:0] output_on_loss;
  logic [7:0] next_output_on_loss;
  logic [7:0] carrier_detect_config;
  logic [7:0] next_carrier_detect_config;
  logic [7:0] squelch_settings;
  logic [7:0] next_squelch_settings;
  logic [7:0] equalizer_bypass_control;
  logic [7:0] next_equalizer_bypass_control;
  logic [7:0] launch_swing_setting;
  logic [7:0] next_launch_swing_setting;
  logic [7:0] cd_window_size;
  logic [7:0] next_cd_window_size;
  logic [7:0] cd_drop_count_reg;
  logic [7:0] next_cd_drop_count_reg;
  logic [7:0] cd_rise_count_reg;
  logic [7:0] next_cd_rise_count_reg;
  logic [7:0] tick_count;
  logic [7:0] next_tick_count;
  logic tick;
  logic next_tick;
  logic squelch_status;
  logic next_squelch_status;
  logic primary_prev;
  logic secondary_prev;
  logic [3:0] primary_cd_change_count;
  logic [3:0] next_primary_cd_change_count;
  logic [3:0] secondary_cd_change_count;
  logic [3:0] next_secondary_cd_change_count;
  logic primary_carrier_detect;
  logic secondary_carrier_detect;
  logic eq_bypass_status;
  logic pin_two_is_input;
  logic pin_sleep;
  logic pin_bypass;
  logic signal_loss;
  logic asleep;
  logic [8:0] squelch_high;
  logic [8:0] squelch_low;
  logic [7:0] next_rdata;
  logic next_mute;
  logic next_disable;
  logic next_lock;
  logic squelch_enable;
  logic [5:0] squelch_threshold;
  logic [1:0] squelch_hysteresis;
  logic eq_auto_bypass_enable;
  logic eq_forced_bypass;
  logic pin_output_enable;
  logic [7:0] cable_length_estimate;
  logic squelch_above;
  logic squelch_below;
  cd_filter_if cd ();

  // reset release through two flip-flops
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_first <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync_first <= 1'b1;
      rst_n <= rst_sync_first;
    end
  end

  assign cd.sample_window = cd_window_size;
  assign cd.rise_count = cd_rise_count_reg;
  assign cd.drop_count = cd_drop_count_reg;
  assign cd.tick = tick;
  assign cd.raw_carrier = raw_carrier_in;
  assign primary_carrier_detect = cd.primary_carrier_detect;

  cd_filter u_cd_filter (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .cd(cd.filter)
  );

  // registers, tick, squelch and counters
  always_comb begin
    next_sleep_control = sleep_control;
    next_pin_two_function = pin_two_function;
    next_pin_two_output_enable = pin_two_output_enable;
    next_output_on_loss = output_on_loss;
    next_carrier_detect_config = carrier_detect_config;
    next_squelch_settings = squelch_settings;
    next_equalizer_bypass_control = equalizer_bypass_control;
    next_launch_swing_setting = launch_swing_setting;
    next_cd_window_size = cd_window_size;
    next_cd_drop_count_reg = cd_drop_count_reg;
    next_cd_rise_count_reg = cd_rise_count_reg;
    if (reg_write_in) begin
      case (reg_addr_in)
        cable_eq_pkg::SLEEP_CONTROL_ADDR: next_sleep_control = reg_wdata_in;
        cable_eq_pkg::PIN_TWO_FUNCTION_ADDR: next_pin_two_function = reg_wdata_in;
        cable_eq_pkg::PIN_TWO_OUTPUT_ENABLE_ADDR: next_pin_two_output_enable = reg_wdata_in;
        cable_eq_pkg::OUTPUT_ON_LOSS_ADDR: next_output_on_loss = reg_wdata_in;
        cable_eq_pkg::CARRIER_DETECT_CONFIG_ADDR: next_carrier_detect_config = reg_wdata_in;
        cable_eq_pkg::SQUELCH_SETTINGS_ADDR: next_squelch_settings = reg_wdata_in;
        cable_eq_pkg::EQUALIZER_BYPASS_CONTROL_ADDR: begin
          next_equalizer_bypass_control = reg_wdata_in;
        end
        cable_eq_pkg::LAUNCH_SWING_SETTING_ADDR: next_launch_swing_setting = reg_wdata_in;
        cable_eq_pkg::CD_WINDOW_SIZE_ADDR: next_cd_window_size = reg_wdata_in;
        cable_eq_pkg::CD_DROP_COUNT_ADDR: next_cd_drop_count_reg = reg_wdata_in;
        cable_eq_pkg::CD_RISE_COUNT_ADDR: next_cd_rise_count_reg = reg_wdata_in;
        default: next_sleep_control = sleep_control;
      endcase
    end

    // field views of the settings registers
    squelch_enable = carrier_detect_config[cable_eq_pkg::SQUELCH_ENABLE_BIT];
    squelch_threshold = squelch_settings[cable_eq_pkg::THRESHOLD_LSB +: 6];
    squelch_hysteresis = squelch_settings[cable_eq_pkg::HYSTERESIS_LSB +: 2];
    eq_auto_bypass_enable = equalizer_bypass_control[cable_eq_pkg::EQ_AUTO_BYPASS_BIT];
    eq_forced_bypass = equalizer_bypass_control[cable_eq_pkg::EQ_FORCED_BYPASS_BIT];
    pin_output_enable = pin_two_output_enable[cable_eq_pkg::PIN_OUTPUT_ENABLE_BIT];
    cable_length_estimate = cable_length_in;

    // 1.6us pacing tick
    next_tick = (tick_count == cable_eq_pkg::CD_TICK_LAST);
    next_tick_count = next_tick ? 8'h00 : tick_count + 8'h01;

    // pin two as input with a selected function
    pin_two_is_input = (pin_output_enable == 1'b0);
    pin_sleep = pin_two_is_input && general_pin_two_in
      && (pin_two_function == cable_eq_pkg::PIN_FUNCTION_SLEEP);
    pin_bypass = pin_two_is_input && general_pin_two_in
      && (pin_two_function == cable_eq_pkg::PIN_FUNCTION_EQ_BYPASS);

    // bypass decision
    if (eq_auto_bypass_enable) begin
      eq_bypass_status = low_rate_in || pin_bypass;
    end else begin
      eq_bypass_status = eq_forced_bypass || pin_bypass;
    end

    // squelch with hysteresis on the cable length estimate
    squelch_high = {3'h0, squelch_threshold} + {7'h00, squelch_hysteresis};
    squelch_low = {3'h0, squelch_threshold} - {7'h00, squelch_hysteresis};
    squelch_above = ({1'b0, cable_length_estimate} > squelch_high);
    // lower bound skipped when hysteresis exceeds threshold
    squelch_below = (squelch_threshold >= {4'h0, squelch_hysteresis})
      && ({1'b0, cable_length_estimate} < squelch_low);
    next_squelch_status = squelch_status;
    if (!squelch_enable) begin
      next_squelch_status = 1'b0;
    end else if (squelch_above) begin
      next_squelch_status = 1'b1;
    end else if (squelch_below) begin
      next_squelch_status = 1'b0;
    end
    if (eq_bypass_status) begin
      next_squelch_status = 1'b0;
    end

    // no lock is reported while squelched
    next_lock = cdr_lock_in && !squelch_status;

    secondary_carrier_detect = ~(squelch_status & primary_carrier_detect);
    signal_loss = ~secondary_carrier_detect || ~primary_carrier_detect;

    // sleep decision
    if (sleep_control[cable_eq_pkg::AUTO_SLEEP_BIT]) begin
      asleep = signal_loss || pin_sleep;
    end else begin
      asleep = sleep_control[cable_eq_pkg::MANUAL_SLEEP_BIT] || pin_sleep;
    end

    // driver state while asleep or on loss
    next_mute = (asleep && !sleep_control[cable_eq_pkg::SLEEP_DRIVER_DISABLE_BIT])
      || (!secondary_carrier_detect && output_on_loss[cable_eq_pkg::MUTE_ON_LOSS_BIT]);
    next_disable = (asleep && sleep_control[cable_eq_pkg::SLEEP_DRIVER_DISABLE_BIT])
      || (!secondary_carrier_detect && output_on_loss[cable_eq_pkg::DISABLE_ON_LOSS_BIT]);

    // change counters saturate and hold
    next_primary_cd_change_count = primary_cd_change_count;
    if ((primary_carrier_detect != primary_prev)
        && (primary_cd_change_count != cable_eq_pkg::CHANGE_COUNT_MAX)) begin
      next_primary_cd_change_count = primary_cd_change_count + 4'h1;
    end
    next_secondary_cd_change_count = secondary_cd_change_count;
    if ((secondary_carrier_detect != secondary_prev)
        && (secondary_cd_change_count != cable_eq_pkg::CHANGE_COUNT_MAX)) begin
      next_secondary_cd_change_count = secondary_cd_change_count + 4'h1;
    end

    // read data
    case (reg_addr_in)
      cable_eq_pkg::SLEEP_CONTROL_ADDR: next_rdata = sleep_control;
      cable_eq_pkg::PIN_TWO_FUNCTION_ADDR: next_rdata = pin_two_function;
      cable_eq_pkg::PIN_TWO_OUTPUT_ENABLE_ADDR: next_rdata = pin_two_output_enable;
      cable_eq_pkg::OUTPUT_ON_LOSS_ADDR: next_rdata = output_on_loss;
      cable_eq_pkg::CARRIER_DETECT_CONFIG_ADDR: next_rdata = carrier_detect_config;
      cable_eq_pkg::SQUELCH_SETTINGS_ADDR: next_rdata = squelch_settings;
      cable_eq_pkg::EQUALIZER_BYPASS_CONTROL_ADDR: next_rdata = equalizer_bypass_control;
      cable_eq_pkg::LAUNCH_SWING_SETTING_ADDR: next_rdata = launch_swing_setting;
      cable_eq_pkg::CD_WINDOW_SIZE_ADDR: next_rdata = cd_window_size;
      cable_eq_pkg::CD_DROP_COUNT_ADDR: next_rdata = cd_drop_count_reg;
      cable_eq_pkg::CD_RISE_COUNT_ADDR: next_rdata = cd_rise_count_reg;
      cable_eq_pkg::CARRIER_CHANGE_COUNTERS_ADDR: begin
        next_rdata = {secondary_cd_change_count, primary_cd_change_count};
      end
      cable_eq_pkg::LIVE_STATUS_A_ADDR: begin
        next_rdata = 8'h00;
        next_rdata[cable_eq_pkg::LOCK_BIT] = next_lock;
        next_rdata[cable_eq_pkg::SQUELCH_STATUS_BIT] = squelch_status;
      end
      cable_eq_pkg::LIVE_STATUS_B_ADDR: begin
        next_rdata = {5'b0_0000, detected_rate_in};
        next_rdata[cable_eq_pkg::PRIMARY_CD_BIT] = primary_carrier_detect;
        next_rdata[cable_eq_pkg::SECONDARY_CD_BIT] = secondary_carrier_detect;
      end
      cable_eq_pkg::CABLE_LENGTH_READING_ADDR: next_rdata = cable_length_estimate;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sleep_control <= cable_eq_pkg::SLEEP_CONTROL_RESET;
      pin_two_function <= cable_eq_pkg::PIN_TWO_FUNCTION_RESET;
      pin_two_output_enable <= cable_eq_pkg::PIN_TWO_OUTPUT_ENABLE_RESET;
      output_on_loss <= cable_eq_pkg::OUTPUT_ON_LOSS_RESET;
      carrier_detect_config <= cable_eq_pkg::CARRIER_DETECT_CONFIG_RESET;
      squelch_settings <= cable_eq_pkg::SQUELCH_SETTINGS_RESET;
      equalizer_bypass_control <= cable_eq_pkg::EQUALIZER_BYPASS_CONTROL_RESET;
      launch_swing_setting <= cable_eq_pkg::LAUNCH_SWING_RESET;
      cd_window_size <= cable_eq_pkg::CD_WINDOW_SIZE_RESET;
      cd_drop_count_reg <= cable_eq_pkg::CD_DROP_COUNT_RESET;
      cd_rise_count_reg <= cable_eq_pkg::CD_RISE_COUNT_RESET;
      tick_count <= 8'h00;
      tick <= 1'b0;
      squelch_status <= 1'b0;
      primary_prev <= 1'b0;
      secondary_prev <= 1'b1;
      primary_cd_change_count <= 4'h0;
      secondary_cd_change_count <= 4'h0;
      reg_rdata_out <= 8'h00;
      general_pin_two_out <= 1'b0;
      general_pin_two_oe_out <= 1'b0;
      sleep_out <= 1'b0;
      driver_mute_out <= 1'b0;
      driver_disable_out <= 1'b0;
      pattern_gen_disable_out <= 1'b0;
      eq_bypass_out <= 1'b0;
      cdr_bypass_out <= 1'b0;
      launch_swing_comp_out <= cable_eq_pkg::LAUNCH_SWING_RESET;
      signal_loss_out <= 1'b0;
      lock_out <= 1'b0;
    end else begin
      sleep_control <= next_sleep_control;
      pin_two_function <= next_pin_two_function;
      pin_two_output_enable <= next_pin_two_output_enable;
      output_on_loss <= next_output_on_loss;
      carrier_detect_config <= next_carrier_detect_config;
      squelch_settings <= next_squelch_settings;
      equalizer_bypass_control <= next_equalizer_bypass_control;
      launch_swing_setting <= next_launch_swing_setting;
      cd_window_size <= next_cd_window_size;
      cd_drop_count_reg <= next_cd_drop_count_reg;
      cd_rise_count_reg <= next_cd_rise_count_reg;
      tick_count <= next_tick_count;
      tick <= next_tick;
      squelch_status <= next_squelch_status;
      primary_prev <= primary_carrier_detect;
      secondary_prev <= secondary_carrier_detect;
      primary_cd_change_count <= next_primary_cd_change_count;
      secondary_cd_change_count <= next_secondary_cd_change_count;
      reg_rdata_out <= next_rdata;
      general_pin_two_out <= signal_loss;
      general_pin_two_oe_out <= pin_output_enable;
      sleep_out <= asleep;
      driver_mute_out <= next_mute;
      driver_disable_out <= next_disable;
      pattern_gen_disable_out <= asleep;
      eq_bypass_out <= eq_bypass_status;
      cdr_bypass_out <= eq_bypass_status;
      launch_swing_comp_out <= launch_swing_setting;
      signal_loss_out <= signal_loss;
      lock_out <= next_lock;
    end
  end
endmodule : cable_eq_signal_detect_ctrl

// *** verif/cable_eq_props_properties.sv ***
// port checks for the cable equalizer control block
`timescale 1ns/1ns
module cable_eq_props (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic cdr_lock_in,
  input wire logic lock_out,
  input wire logic eq_bypass_out,
  input wire logic cdr_bypass_out,
  input wire logic sleep_out,
  input wire logic pattern_gen_disable_out,
  input wire logic [7:0] launch_swing_comp_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  property p_lock; lock_out |-> $past(cdr_lock_in); endproperty
  a_lock: assert property (p_lock) else $error("lock without recovery lock");
  property p_byp_pair; eq_bypass_out == cdr_bypass_out; endproperty
  a_byp_pair: assert property (p_byp_pair) else $error("bypass pair split");
  property p_pgen; pattern_gen_disable_out == sleep_out; endproperty
  a_pgen: assert property (p_pgen) else $error("generator not off in sleep");
  property p_forced; reg_write_in && reg_addr_in == 8'h17 && reg_wdata_in[1:0] == 2'b10
    |-> ##2 eq_bypass_out; endproperty
  a_forced: assert property (p_forced) else $error("forced bypass missing");
  property p_swing; reg_write_in && reg_addr_in == 8'h18
    |-> ##2 launch_swing_comp_out == $past(reg_wdata_in, 2); endproperty
  a_swing: assert property (p_swing) else $error("swing not updated");
  property p_swing_rst; $rose(arst_n_in) |-> launch_swing_comp_out == 8'h50; endproperty
  a_swing_rst: assert property (p_swing_rst) else $error("swing reset value");
  property p_unmapped; reg_addr_in == 8'hff |=> reg_rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_readback; reg_write_in && reg_addr_in == 8'h22 ##1
    reg_addr_in == 8'h22 && !reg_write_in |=> reg_rdata_out == $past(reg_wdata_in, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("rise count readback");
  property p_man_sleep; reg_write_in && reg_addr_in == 8'h03 && reg_wdata_in[1:0] == 2'b10
    |-> ##[2:3] sleep_out; endproperty
  a_man_sleep: assert property (p_man_sleep) else $error("manual sleep missing");
endmodule : cable_eq_props
bind cable_eq_signal_detect_ctrl cable_eq_props u_props (.clock_in, .arst_n_in, .reg_addr_in,
  .reg_wdata_in, .reg_write_in, .reg_rdata_out, .cdr_lock_in, .lock_out, .eq_bypass_out,
  .cdr_bypass_out, .sleep_out, .pattern_gen_disable_out, .launch_swing_comp_out);

// *** verif/coax_source.sv ***
// upstream coax source: carrier, cable length and recovery status
`timescale 1ns/1ns
module coax_source (
  input wire logic carrier_on_in,
  input wire logic [7:0] length_in,
  output logic raw_carrier_out,
  output logic [7:0] cable_length_out,
  output logic cdr_lock_out,
  output logic [2:0] rate_out
);
  assign raw_carrier_out = carrier_on_in;
  assign cable_length_out = length_in;
  assign cdr_lock_out = carrier_on_in;
  assign rate_out = carrier_on_in ? 3'h3 : 3'h0;
endmodule : coax_source

// *** verif/cable_eq_signal_detect_ctrl_test.sv ***
// self-checking bench for the cable equalizer control block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module cable_eq_signal_detect_ctrl_test;
  logic clock_in = '0, arst_n_in = '0, reg_write_in = '0, low_rate_in = '0;
  logic pin_drv = '0, carrier_on = '0, sq = '0;
  logic [7:0] reg_addr_in = '0, reg_wdata_in = '0, length = 8'h14, v, d;
  logic [7:0] reg_rdata_out, launch_swing_comp_out, cable_length_in;
  logic [2:0] detected_rate_in;
  logic raw_carrier_in, cdr_lock_in, general_pin_two_in, general_pin_two_out, sleep_out;
  logic general_pin_two_oe_out, driver_mute_out, driver_disable_out, pattern_gen_disable_out;
  logic eq_bypass_out, cdr_bypass_out, signal_loss_out, lock_out;
  int num_errors = 0, num_checks = 0, cycles = 0;
  logic [15:0] tbl [12] = '{16'h0301, 16'h1283, 16'h1300, 16'h1400, 16'h1500, 16'h1660,
    16'h1701, 16'h1850, 16'h203b, 16'h2101, 16'h2244, 16'hff00};
  always #5 clock_in = ~clock_in;
  assign general_pin_two_in = general_pin_two_oe_out ? general_pin_two_out : pin_drv;
  coax_source src (.carrier_on_in(carrier_on), .length_in(length),
    .raw_carrier_out(raw_carrier_in), .cable_length_out(cable_length_in),
    .cdr_lock_out(cdr_lock_in), .rate_out(detected_rate_in));
  cable_eq_signal_detect_ctrl dut (.clock_in, .arst_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_write_in, .reg_rdata_out, .raw_carrier_in, .low_rate_in, .cable_length_in,
    .cdr_lock_in, .detected_rate_in, .general_pin_two_in, .general_pin_two_out,
    .general_pin_two_oe_out, .sleep_out, .driver_mute_out, .driver_disable_out,
    .pattern_gen_disable_out, .eq_bypass_out, .cdr_bypass_out, .launch_swing_comp_out,
    .signal_loss_out, .lock_out);
  function automatic logic sq_next(input logic [7:0] c, input logic p);
    if (c > 8'h21) return 1'b1;
    if (c < 8'h1f) return 1'b0;
    return p;
  endfunction : sq_next
  task automatic waitc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : waitc
  task automatic wr(input logic [7:0] a, input logic [7:0] x);
    waitc(1);
    reg_addr_in = a;
    reg_wdata_in = x;
    reg_write_in = 1'b1;
    waitc(1);
    reg_write_in = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    waitc(1);
    reg_addr_in = a;
    waitc(1);
    v = reg_rdata_out;
  endtask : rd
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    v = $urandom(86440);
    repeat (4) @(posedge clock_in);
    #1 arst_n_in = 1'b1;
    waitc(3);
    foreach (tbl[i]) begin
      rd(tbl[i][15:8]);
      `CHK("reset value", tbl[i][7:0], v)
    end
    wr(8'h88, 8'h5a);
    rd(8'h88);
    `CHK("read only", length, v)
    `CHK("asleep", 2'b11, {sleep_out, pattern_gen_disable_out})
    wr(8'h13, 8'h01);
    waitc(1);
    `CHK("pin out", 2'b11, {general_pin_two_oe_out, general_pin_two_out})
    wr(8'h13, 8'h00);
    $display("reset done");
    wr(8'h20, 8'h01);
    wr(8'h21, 8'h02);
    wr(8'h22, 8'h03);
    rd(8'h22);
    carrier_on = 1'b1;
    waitc(700);
    rd(8'h87);
    `CHK("early detect", 1'b0, v[3])
    waitc(800);
    rd(8'h87);
    `CHK("detect", 2'b11, v[4:3])
    `CHK("awake", 2'b00, {sleep_out, signal_loss_out})
    rd(8'h84);
    `CHK("pri count", 4'h1, v[3:0])
    $display("filter done");
    wr(8'h03, 8'h03);
    waitc(3);
    `CHK("auto ignores", 1'b0, sleep_out)
    wr(8'h03, 8'h06);
    waitc(3);
    `CHK("disable", 3'b110, {sleep_out, driver_disable_out, driver_mute_out})
    wr(8'h03, 8'h02);
    waitc(3);
    `CHK("mute", 3'b101, {sleep_out, driver_disable_out, driver_mute_out})
    wr(8'h03, 8'h00);
    pin_drv = 1'b1;
    waitc(4);
    `CHK("pin sleep", 1'b1, sleep_out)
    pin_drv = 1'b0;
    wr(8'h03, 8'h01);
    $display("sleep done");
    length = 8'h28;
    rd(8'h86);
    `CHK("squelch off", 1'b0, v[1])
    wr(8'h15, 8'h01);
    waitc(2);
    sq = 1'b1;
    repeat (12) begin
      length = 8'h1c + 8'($urandom % 8'h0a);
      waitc(4);
      sq = sq_next(length, sq);
      rd(8'h86);
      `CHK("squelch", {sq, ~sq}, v[1:0])
      `CHK("loss", sq, signal_loss_out)
      `CHK("lock", ~sq, lock_out)
    end
    repeat (8) begin
      length = 8'h10;
      waitc(3);
      length = 8'h28;
      waitc(3);
    end
    rd(8'h84);
    `CHK("change counts", 8'hf1, v)
    length = 8'h28;
    rd(8'h87);
    waitc(3);
    rd(8'h87);
    `CHK("secondary", 2'b01, {v[4], v[3]})
    $display("squelch done");
    wr(8'h17, 8'h02);
    rd(8'h86);
    `CHK("forced", 2'b01, {v[1], eq_bypass_out})
    wr(8'h17, 8'h01);
    low_rate_in = 1'b1;
    waitc(3);
    `CHK("auto bypass", 1'b1, eq_bypass_out)
    low_rate_in = 1'b0;
    wr(8'h12, 8'h84);
    pin_drv = 1'b1;
    waitc(8);
    `CHK("pin bypass", 2'b10, {eq_bypass_out, sleep_out})
    pin_drv = 1'b0;
    d = 8'($urandom);
    wr(8'h18, d);
    waitc(1);
    `CHK("swing", d, launch_swing_comp_out)
    $display("bypass done");
    length = 8'h14;
    carrier_on = 1'b0;
    waitc(400);
    rd(8'h87);
    `CHK("held", 1'b1, v[3])
    waitc(700);
    rd(8'h87);
    `CHK("dropped", 2'b01, {v[3], sleep_out})
    rd(8'h84);
    `CHK("pri count", 4'h2, v[3:0])
    $display("loss done");
    summarize();
  end
endmodule : cable_eq_signal_detect_ctrl_test
